// *** tms_defs.vh ***
/*
 * constants of the two-timer trigger linkage: register word indices, field
 * positions, mode encodings, reset values and the alignment delay.
 * assumes word-aligned byte addresses on the plain register port.
 */
`ifndef TMS_DEFS_VH
`define TMS_DEFS_VH

// ----------------------------------------------------------------------
// address decode
// ----------------------------------------------------------------------
`define TMS_ADDR_W 8
`define TMS_IDX_RANGE 4:2
`define TMS_SEL_BIT 5
`define TMS_TOP_RANGE 7:6
`define TMS_TOP_OK 2'h0

// ----------------------------------------------------------------------
// word indices inside one timer (byte address = base + 4 * index)
// ----------------------------------------------------------------------
`define TMS_REG_CTRL 3'h0
`define TMS_REG_MODE 3'h1
`define TMS_REG_EVENT 3'h2
`define TMS_REG_COUNT 3'h3
`define TMS_REG_PRESC 3'h4
`define TMS_REG_RELOAD 3'h5
`define TMS_REG_CMP1 3'h6
`define TMS_REG_FLAG 3'h7

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define TMS_CTRL_RUN 0
`define TMS_CTRL_ALIGN 1
`define TMS_EVENT_UG 0
`define TMS_FLAG_TRIG 0
`define TMS_MODE_W 20
`define TMS_MODE_MMS 2:0
`define TMS_MODE_TS 6:4
`define TMS_MODE_SMS 10:8
`define TMS_MODE_ETS 13:12
`define TMS_MODE_ETP 14
`define TMS_MODE_ECE 15
`define TMS_MODE_MSKEN 16
`define TMS_MODE_CCP 17
`define TMS_MODE_ETPS 19:18
`define TMS_CNT_W 16
`define TMS_CNT_RANGE 15:0
`define TMS_MMS_CMP_BIT 2

// ----------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------
`define TMS_MMS_RESET 3'h0
`define TMS_MMS_ENABLE 3'h1
`define TMS_MMS_UPDATE 3'h2
`define TMS_TS_ITR 3'h0
`define TMS_TS_CH1 3'h5
`define TMS_TS_EXTF 3'h7
`define TMS_SMS_RESET 3'h4
`define TMS_SMS_GATED 3'h5
`define TMS_SMS_TRIG 3'h6
`define TMS_SMS_EXT1 3'h7
`define TMS_ETS_OWN 2'h0
`define TMS_ETS_OTHER 2'h1

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define TMS_RST_MODE 20'h00000
`define TMS_RST_CNT 16'h0000
`define TMS_RST_RELOAD 16'hFFFF
`define TMS_ALIGN_DLY 3

`endif

// *** tms_timer_pair.v ***
/*
 * two linked general-purpose timers: master trigger output, slave trigger
 * input selection, gated / trigger / external clock 1 / reset slave modes,
 * external trigger conditioning, and the plain register port.
 * assumes all inputs synchronous to i_clk (peripheral clock), one access
 * per strobe, read data taken in the cycle after the read strobe.
 */
`include "tms_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module tms_timer (
	input wire i_clk,
	input wire i_rst_b,
	input wire i_wr,
	input wire [2:0] i_idx,
	input wire [31:0] i_wdata,
	input wire i_internal_trigger_in,
	input wire i_channel1_input,
	input wire i_own_clock_pin,
	input wire i_other_clock_pin,
	input wire i_clock_mask_pin,
	output reg [31:0] o_rd_word,
	output reg o_trigger_out_q,
	output reg o_compare_output_q
);

	function rise;
		input cur;
		input prev;
		begin
			rise = cur & ~prev;
		end
	endfunction

	function wr_sel;
		input wr;
		input [2:0] idx;
		input [2:0] which;
		begin
			wr_sel = wr & (idx == which);
		end
	endfunction

	// ----------------------------------------------------------------------
	// register write decode
	// ----------------------------------------------------------------------
	wire wr_ctrl = wr_sel(i_wr, i_idx, `TMS_REG_CTRL);
	wire wr_mode = wr_sel(i_wr, i_idx, `TMS_REG_MODE);
	wire wr_event = wr_sel(i_wr, i_idx, `TMS_REG_EVENT);
	wire wr_count = wr_sel(i_wr, i_idx, `TMS_REG_COUNT);
	wire wr_presc = wr_sel(i_wr, i_idx, `TMS_REG_PRESC);
	wire wr_reload = wr_sel(i_wr, i_idx, `TMS_REG_RELOAD);
	wire wr_cmp1 = wr_sel(i_wr, i_idx, `TMS_REG_CMP1);
	wire wr_flag = wr_sel(i_wr, i_idx, `TMS_REG_FLAG);

	reg run_q;
	reg align_q;
	reg [`TMS_MODE_W-1:0] mode_q;
	reg [`TMS_CNT_RANGE] cnt_q;
	reg [`TMS_CNT_RANGE] psc_q;
	reg [`TMS_CNT_RANGE] pscc_q;
	reg [`TMS_CNT_RANGE] arr_q;
	reg [`TMS_CNT_RANGE] ccr_q;
	reg flag_q;
	reg slv_trg_q;
	reg slv_trg_prev_q;
	reg ext_q;
	reg ext_prev_q;
	reg [2:0] etps_cnt_q;
	reg ext_cond_q;
	reg ext_filt_q;
	reg [`TMS_ALIGN_DLY-1:0] en_sr_q;

	wire [2:0] mms = mode_q[`TMS_MODE_MMS];
	wire [2:0] ts = mode_q[`TMS_MODE_TS];
	wire [2:0] sms = mode_q[`TMS_MODE_SMS];
	wire [1:0] ets = mode_q[`TMS_MODE_ETS];
	wire [1:0] etps = mode_q[`TMS_MODE_ETPS];

	// ----------------------------------------------------------------------
	// slave trigger input
	// ----------------------------------------------------------------------
	reg trg_sel;
	always @* begin
		case (ts)
			`TMS_TS_ITR: trg_sel = i_internal_trigger_in;
			`TMS_TS_CH1: trg_sel = i_channel1_input;
			`TMS_TS_EXTF: trg_sel = ext_filt_q;
			default: trg_sel = 1'b0;
		endcase
	end

	// one resync stage: the receiver sees a pulse one clock after it leaves
	wire trg_rise = rise(slv_trg_q, slv_trg_prev_q);
	wire trg_fall = rise(slv_trg_prev_q, slv_trg_q);

	// ----------------------------------------------------------------------
	// external trigger conditioning
	// ----------------------------------------------------------------------
	reg ext_src;
	always @* begin
		case (ets)
			`TMS_ETS_OWN: ext_src = i_own_clock_pin;
			`TMS_ETS_OTHER: ext_src = i_other_clock_pin &
				(~mode_q[`TMS_MODE_MSKEN] | i_clock_mask_pin);
			default: ext_src = 1'b0;
		endcase
	end

	wire ext_edge = rise(ext_q, ext_prev_q);
	wire [2:0] etps_lim = (3'h1 << etps) - 3'h1;

	// ----------------------------------------------------------------------
	// counting control
	// ----------------------------------------------------------------------
	wire ug = wr_event & i_wdata[`TMS_EVENT_UG];
	wire gated = (sms == `TMS_SMS_GATED);
	wire en = run_q & (~gated | slv_trg_q);
	// align mode holds the prescaler back until slaves have resynced
	wire psc_en = align_q ? en_sr_q[`TMS_ALIGN_DLY-1] : en;
	wire tick = (sms == `TMS_SMS_EXT1) ? trg_rise :
		(mode_q[`TMS_MODE_ECE] ? ext_filt_q : 1'b1);
	wire reinit = ug | ((sms == `TMS_SMS_RESET) & trg_rise);
	wire step = psc_en & tick & (pscc_q == psc_q);
	wire ovf = step & (cnt_q == arr_q);
	wire upd_evt = reinit | ovf;
	wire trg_start = (sms == `TMS_SMS_TRIG) & trg_rise;
	wire cmp_ref = (cnt_q < ccr_q);
	wire flag_set = gated ? (trg_rise | trg_fall) : trg_rise;

	reg trigger_out_d;
	always @* begin
		case (mms)
			`TMS_MMS_RESET: trigger_out_d = reinit;
			`TMS_MMS_ENABLE: trigger_out_d = en;
			`TMS_MMS_UPDATE: trigger_out_d = upd_evt;
			default: trigger_out_d = mms[`TMS_MMS_CMP_BIT] & cmp_ref;
		endcase
	end

	// ----------------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------------
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			run_q <= 1'b0;
			align_q <= 1'b0;
			mode_q <= `TMS_RST_MODE;
			psc_q <= `TMS_RST_CNT;
			arr_q <= `TMS_RST_RELOAD;
			ccr_q <= `TMS_RST_CNT;
			flag_q <= 1'b0;
		end else begin
			if (trg_start) begin
				run_q <= 1'b1;
			end else if (wr_ctrl) begin
				run_q <= i_wdata[`TMS_CTRL_RUN];
			end
			if (wr_ctrl) begin
				align_q <= i_wdata[`TMS_CTRL_ALIGN];
			end
			if (wr_mode) begin
				mode_q <= i_wdata[`TMS_MODE_W-1:0];
			end
			if (wr_presc) begin
				psc_q <= i_wdata[`TMS_CNT_RANGE];
			end
			if (wr_reload) begin
				arr_q <= i_wdata[`TMS_CNT_RANGE];
			end
			if (wr_cmp1) begin
				ccr_q <= i_wdata[`TMS_CNT_RANGE];
			end
			// a set in the clearing cycle wins
			if (flag_set) begin
				flag_q <= 1'b1;
			end else if (wr_flag && i_wdata[`TMS_FLAG_TRIG]) begin
				flag_q <= 1'b0;
			end
		end
	end

	// counter and prescaler keep their values unless reinitialised, loaded or stepped
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			cnt_q <= `TMS_RST_CNT;
			pscc_q <= `TMS_RST_CNT;
		end else begin
			if (wr_count) begin
				cnt_q <= i_wdata[`TMS_CNT_RANGE];
			end else if (reinit) begin
				cnt_q <= `TMS_RST_CNT;
			end else if (step) begin
				cnt_q <= ovf ? `TMS_RST_CNT : cnt_q + 16'h0001;
			end
			if (reinit) begin
				pscc_q <= `TMS_RST_CNT;
			end else if (psc_en & tick) begin
				pscc_q <= (pscc_q == psc_q) ? `TMS_RST_CNT : pscc_q + 16'h0001;
			end
		end
	end

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			slv_trg_q <= 1'b0;
			slv_trg_prev_q <= 1'b0;
			ext_q <= 1'b0;
			ext_prev_q <= 1'b0;
			etps_cnt_q <= 3'h0;
			ext_cond_q <= 1'b0;
			ext_filt_q <= 1'b0;
			en_sr_q <= {`TMS_ALIGN_DLY{1'b0}};
			o_trigger_out_q <= 1'b0;
			o_compare_output_q <= 1'b0;
		end else begin
			slv_trg_q <= trg_sel;
			slv_trg_prev_q <= slv_trg_q;
			ext_q <= ext_src ^ mode_q[`TMS_MODE_ETP];
			ext_prev_q <= ext_q;
			if (ext_edge) begin
				etps_cnt_q <= (etps_cnt_q == etps_lim) ? 3'h0 : etps_cnt_q + 3'h1;
			end
			ext_cond_q <= ext_edge & (etps_cnt_q == etps_lim);
			// filter stage: a single retiming flop, no programmable length
			ext_filt_q <= ext_cond_q;
			en_sr_q <= {en_sr_q[`TMS_ALIGN_DLY-2:0], en};
			o_trigger_out_q <= trigger_out_d;
			o_compare_output_q <= cmp_ref ^ mode_q[`TMS_MODE_CCP];
		end
	end

	// ----------------------------------------------------------------------
	// read view
	// ----------------------------------------------------------------------
	always @* begin
		case (i_idx)
			`TMS_REG_CTRL: o_rd_word = {30'h0, align_q, run_q};
			`TMS_REG_MODE: o_rd_word = {12'h000, mode_q};
			`TMS_REG_COUNT: o_rd_word = {16'h0000, cnt_q};
			`TMS_REG_PRESC: o_rd_word = {16'h0000, psc_q};
			`TMS_REG_RELOAD: o_rd_word = {16'h0000, arr_q};
			`TMS_REG_CMP1: o_rd_word = {16'h0000, ccr_q};
			`TMS_REG_FLAG: o_rd_word = {31'h0, flag_q};
			default: o_rd_word = 32'h00000000;
		endcase
	end

endmodule

module tms_timer_pair (
	input wire i_clk,
	input wire i_rst_b,
	input wire [`TMS_ADDR_W-1:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_we,
	input wire i_re,
	output reg [31:0] o_rdata,
	input wire [1:0] i_channel1_input,
	input wire [1:0] i_external_clock_pin,
	input wire [1:0] i_clock_mask_pin,
	output wire [1:0] o_trigger_out,
	output wire [1:0] o_compare_output
);

	wire valid = (i_addr[`TMS_TOP_RANGE] == `TMS_TOP_OK);
	wire sel = i_addr[`TMS_SEL_BIT];
	wire [2:0] idx = i_addr[`TMS_IDX_RANGE];
	wire [31:0] rd0;
	wire [31:0] rd1;

	// ----------------------------------------------------------------------
	// the two timers, each triggered by the other
	// ----------------------------------------------------------------------
	tms_timer u_tim0 (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_wr(i_we & valid & ~sel),
		.i_idx(idx),
		.i_wdata(i_wdata),
		.i_internal_trigger_in(o_trigger_out[1]),
		.i_channel1_input(i_channel1_input[0]),
		.i_own_clock_pin(i_external_clock_pin[0]),
		.i_other_clock_pin(i_external_clock_pin[1]),
		.i_clock_mask_pin(i_clock_mask_pin[0]),
		.o_rd_word(rd0),
		.o_trigger_out_q(o_trigger_out[0]),
		.o_compare_output_q(o_compare_output[0])
	);

	tms_timer u_tim1 (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_wr(i_we & valid & sel),
		.i_idx(idx),
		.i_wdata(i_wdata),
		.i_internal_trigger_in(o_trigger_out[0]),
		.i_channel1_input(i_channel1_input[1]),
		.i_own_clock_pin(i_external_clock_pin[1]),
		.i_other_clock_pin(i_external_clock_pin[0]),
		.i_clock_mask_pin(i_clock_mask_pin[1]),
		.o_rd_word(rd1),
		.o_trigger_out_q(o_trigger_out[1]),
		.o_compare_output_q(o_compare_output[1])
	);

	// ----------------------------------------------------------------------
	// read data, one cycle after the strobe; unmapped reads return zero
	// ----------------------------------------------------------------------
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_rdata <= 32'h00000000;
		end else if (i_re && valid) begin
			o_rdata <= sel ? rd1 : rd0;
		end else begin
			o_rdata <= 32'h00000000;
		end
	end

endmodule

`default_nettype wire

// *** tms_timer_pair_asserts.sv ***
/* port checker for the timer pair: bus answers, trigger and compare outputs.
   assumes it is bound to tms_timer_pair: one clock, synchronous reset. */
`timescale 1ns/100ps
`default_nettype none
module tms_pair_chk (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0] o_trigger_out,
	input wire logic [1:0] o_compare_output
);
	// ----
	// shadow of written mode and run bits
	// ----
	// run shadow misses hardware sets, so enable checks skip gated and trigger modes
	logic [19:0] md_q [0:1];
	logic [1:0] run_q;
	logic slv1;
	assign slv1 = md_q[1][10:8] == 3'h6 && md_q[1][6:4] == 3'h0 && md_q[1][2:0] == 3'h1;
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			md_q[0] <= 20'h00000;
			md_q[1] <= 20'h00000;
			run_q <= 2'h0;
		end else if (i_we && i_addr[7:6] == 2'h0) begin
			if (i_addr[4:2] == 3'h1)
				md_q[i_addr[5]] <= i_wdata[19:0];
			if (i_addr[4:2] == 3'h0)
				run_q[i_addr[5]] <= i_wdata[0];
		end
	end
	// ----
	// assertions
	// ----
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_t0_rise; $rose(o_trigger_out[0]); endsequence
	sequence s_t1_run; ##[1:4] o_trigger_out[1]; endsequence
	property p_rd_idle; !i_re |=> o_rdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
	property p_rd_unmap; i_re && i_addr[7:6] != 2'h0 |=> o_rdata == 32'h0; endproperty
	a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
	property p_rd_md0; i_re && i_addr == 8'h04 |=> o_rdata == {12'h000, md_q[0]}; endproperty
	a_rd_md0: assert property (p_rd_md0) else $error("mode0 readback wrong");
	property p_rd_md1; i_re && i_addr == 8'h24 |=> o_rdata == {12'h000, md_q[1]}; endproperty
	a_rd_md1: assert property (p_rd_md1) else $error("mode1 readback wrong");
	property p_upd;
		$past(md_q[0][2:0]) == 3'h2 && $rose(o_trigger_out[0]) |=> !o_trigger_out[0];
	endproperty
	a_upd: assert property (p_upd) else $error("update trigger longer than one cycle");
	property p_cmp;
		$past(md_q[0][2]) |-> o_compare_output[0] == (o_trigger_out[0] ^ $past(md_q[0][17]));
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare out differs from reference");
	property p_en0;
		$past(md_q[0][2:0]) == 3'h1 && $past(md_q[0][10:8]) < 3'h5
			|-> o_trigger_out[0] == $past(run_q[0]);
	endproperty
	a_en0: assert property (p_en0) else $error("trigger out not counter enable");
	property p_chain; slv1 ##0 s_t0_rise |-> s_t1_run; endproperty
	a_chain: assert property (p_chain) else $error("slave did not start");
endmodule
bind tms_timer_pair tms_pair_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
	.o_trigger_out(o_trigger_out), .o_compare_output(o_compare_output));
`default_nettype wire

// *** tms_pin_model.sv ***
/* outside pin source: bursts of five clock-pin pulses and a channel 1 step.
   assumes the pair's clock; pins idle low between bursts. */
`timescale 1ns/100ps
`default_nettype none
module tms_pin_model (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [1:0] i_sel,
	input wire logic i_step,
	output logic [1:0] o_clk_pin,
	output logic [1:0] o_ch1
);
	// ----
	// burst generator
	// ----
	// two cycles per level so the receiver's retiming flop sees every edge
	logic [3:0] left_q = 4'h0;
	logic slow_q = 1'b0;
	logic lvl_q = 1'b0;
	logic step_q = 1'b0;
	always @(posedge i_clk) begin
		step_q <= i_step;
		slow_q <= ~slow_q;
		if (i_go)
			left_q <= 4'hA;
		else if (left_q != 4'h0 && slow_q) begin
			left_q <= left_q - 4'h1;
			lvl_q <= ~lvl_q;
		end
	end
	assign o_clk_pin = i_sel & {2{lvl_q}};
	assign o_ch1 = {1'b0, step_q};
endmodule
`default_nettype wire

// *** tb_tms_timer_pair.sv ***
/* self-checking bench of the timer pair through its register port.
   assumes the checker binds itself and the pin model drives the clock and channel 1 pins. */
`timescale 1ns/100ps
`default_nettype none
module tb_tms_timer_pair;
	logic clk;
	logic rst_b;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic we;
	logic re;
	logic [31:0] rdata;
	logic [1:0] ch1;
	logic [1:0] pin;
	logic [1:0] msk;
	logic [1:0] trig;
	logic [1:0] cmp;
	logic go;
	logic [1:0] sel;
	logic step;
	logic [31:0] rv;
	logic tp = 1'b0;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	int nrise = 0;
	int base;
	tms_timer_pair uut (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
		.i_we(we), .i_re(re), .o_rdata(rdata), .i_channel1_input(ch1),
		.i_external_clock_pin(pin), .i_clock_mask_pin(msk), .o_trigger_out(trig),
		.o_compare_output(cmp));
	tms_pin_model u_pins (.i_clk(clk), .i_go(go), .i_sel(sel), .i_step(step),
		.o_clk_pin(pin), .o_ch1(ch1));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ----
	// tasks
	// ----
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests = n_tests + 1;
		if (s !== e) begin
			fails = fails + 1;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chb(input string nm, input logic s, input logic e);
		chk(nm, {31'h0, s}, {31'h0, e});
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1;
		rv = rdata;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(nm, rv, e);
	endtask
	task automatic burst(input logic [1:0] s, input logic [1:0] m);
		@(posedge clk);
		sel <= s;
		msk <= m;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		idle(30);
	endtask
	// ----
	// trig0 rise tally and hang guard
	// ----
	always @(posedge clk) begin
		cyc <= cyc + 1;
		tp <= trig[0];
		if (trig[0] === 1'b1 && tp === 1'b0)
			nrise <= nrise + 1;
		if (cyc == 3000) begin
			fails = fails + 1;
			give_verdict();
		end
	end
	// ----
	// tests
	// ----
	initial begin
		rst_b = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		we = 1'b0;
		re = 1'b0;
		msk = 2'h0;
		go = 1'b0;
		sel = 2'h0;
		step = 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		rdc("mode0", 8'h04, 32'h0);
		rdc("reload0", 8'h14, 32'hFFFF);
		wr(8'h40, 32'h1);
		rdc("ctrl0", 8'h00, 32'h0);
		rdc("unmapped", 8'h40, 32'h0);
		wr(8'h2C, 32'hE7);
		rdc("count1", 8'h2C, 32'hE7);
		wr(8'h28, 32'h1);
		rdc("count1 ug", 8'h2C, 32'h0);
		wr(8'h2C, 32'hE7);
		$display("test registers done");
		wr(8'h04, 32'h1);
		wr(8'h00, 32'h1);
		idle(2);
		chb("trig0 run", trig[0], 1'b1);
		wr(8'h00, 32'h0);
		idle(2);
		chb("trig0 stop", trig[0], 1'b0);
		wr(8'h18, 32'h10);
		wr(8'h0C, 32'h0);
		wr(8'h04, 32'h4);
		wr(8'h00, 32'h1);
		idle(2);
		chb("trig0 ref", trig[0], 1'b1);
		chb("cmp0", cmp[0], 1'b1);
		wr(8'h04, 32'h20004);
		idle(2);
		chb("cmp0 inv", cmp[0], 1'b0);
		idle(20);
		chb("trig0 ref low", trig[0], 1'b0);
		wr(8'h00, 32'h0);
		$display("test master outputs done");
		wr(8'h14, 32'h3);
		wr(8'h0C, 32'h0);
		wr(8'h24, 32'h601);
		rdc("mode1", 8'h24, 32'h601);
		wr(8'h04, 32'h2);
		wr(8'h00, 32'h1);
		for (int k = 0; k < 40 && trig[0] !== 1'b1; k++)
			idle(1);
		chb("trig0 seen", trig[0], 1'b1);
		idle(1);
		chb("trig0 pulse", trig[0], 1'b0);
		wr(8'h00, 32'h0);
		idle(4);
		rdc("run1 hw", 8'h20, 32'h1);
		rdc("flag1", 8'h3C, 32'h1);
		wr(8'h20, 32'h0);
		rdc("run1 sw", 8'h20, 32'h0);
		rd(8'h2C);
		chb("count1 kept", rv >= 32'hE7, 1'b1);
		wr(8'h2C, 32'h0);
		wr(8'h24, 32'h700);
		wr(8'h20, 32'h1);
		base = nrise;
		wr(8'h00, 32'h1);
		idle(30);
		wr(8'h00, 32'h0);
		idle(4);
		rdc("count1 ext1", 8'h2C, 32'(nrise - base));
		chk("trig0 rate", 32'(nrise - base), 32'h8);
		wr(8'h18, 32'h2);
		wr(8'h04, 32'h4);
		idle(4);
		wr(8'h2C, 32'h0);
		base = nrise;
		wr(8'h00, 32'h1);
		idle(30);
		wr(8'h00, 32'h0);
		idle(4);
		chk("ref rate", 32'(nrise - base), 32'h8);
		rdc("count1 ref clk", 8'h2C, 32'(nrise - base));
		$display("test trigger chain done");
		wr(8'h2C, 32'h0);
		wr(8'h24, 32'h500);
		wr(8'h04, 32'h1);
		wr(8'h3C, 32'h1);
		idle(6);
		rdc("count1 gate off", 8'h2C, 32'h0);
		wr(8'h00, 32'h1);
		idle(6);
		wr(8'h00, 32'h0);
		idle(4);
		rd(8'h2C);
		chb("count1 gated", rv != 32'h0, 1'b1);
		rdc("count1 held", 8'h2C, rv);
		rdc("flag1 gated", 8'h3C, 32'h1);
		chb("cmp1 low", cmp[1], 1'b0);
		wr(8'h38, 32'hFFFF);
		idle(2);
		chb("cmp1", cmp[1], 1'b1);
		wr(8'h20, 32'h0);
		$display("test gated done");
		wr(8'h14, 32'hFFFF);
		wr(8'h0C, 32'h0);
		wr(8'h04, 32'h8000);
		wr(8'h00, 32'h1);
		burst(2'h1, 2'h0);
		rdc("count0 etr", 8'h0C, 32'h5);
		wr(8'h0C, 32'h0);
		wr(8'h04, 32'h19000);
		burst(2'h2, 2'h0);
		rdc("count0 masked", 8'h0C, 32'h0);
		burst(2'h2, 2'h1);
		rdc("count0 unmasked", 8'h0C, 32'h5);
		wr(8'h00, 32'h0);
		$display("test external clock done");
		wr(8'h28, 32'h1);
		wr(8'h08, 32'h1);
		wr(8'h04, 32'h651);
		wr(8'h00, 32'h2);
		wr(8'h24, 32'h601);
		wr(8'h1C, 32'h1);
		wr(8'h3C, 32'h1);
		@(posedge clk);
		step <= 1'b1;
		idle(8);
		rdc("ctrl0 start", 8'h00, 32'h3);
		rdc("run1 start", 8'h20, 32'h1);
		chb("trig1 start", trig[1], 1'b1);
		rdc("flag0 start", 8'h1C, 32'h1);
		rdc("flag1 start", 8'h3C, 32'h1);
		$display("test joint start done");
		give_verdict();
	end
endmodule
`default_nettype wire
